// ===== design/adcstc_top.v
`include "adcstc_defs.vh"
`default_nettype none
module adcstc_top (
   input  wire        SYS_CLK_IN,
   input  wire        SRST_IN,
   input  wire [7:0]  AWADDR_IN,
   input  wire        AWVALID_IN,
   output reg         AWREADY_OUT,
   input  wire [31:0] WDATA_IN,
   input  wire [3:0]  WSTRB_IN,
   input  wire        WVALID_IN,
   output reg         WREADY_OUT,
   output reg  [1:0]  BRESP_OUT,
   output reg         BVALID_OUT,
   input  wire        BREADY_IN,
   input  wire [7:0]  ARADDR_IN,
   input  wire        ARVALID_IN,
   output reg         ARREADY_OUT,
   output reg  [31:0] RDATA_OUT,
   output reg  [1:0]  RRESP_OUT,
   output reg         RVALID_OUT,
   input  wire        RREADY_IN,
   input  wire        EXT_TRIGGER_IN,
   input  wire        CONV_DONE_IN,
   output reg         CONV_CLK_EN_OUT,
   output reg         SAMPLE_OUT,
   output reg         CONVERT_OUT,
   output reg         CONV_START_OUT,
   output reg         SPECIAL_SEL_OUT,
   output reg  [3:0]  CHANNEL_OUT,
   output reg  [3:0]  RESULT_SLOT_OUT,
   output reg         BUSY_OUT,
   output reg         IRQ_OUT
);
   // one-hot sequencer states
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_SAMP = 3'b010;
   localparam [2:0] ST_CONV = 3'b100;

   reg  [7:0]  timing_ff;
   reg  [7:0]  start_ff;
   reg  [7:0]  ctl0_ff;
   reg  [4:0]  conv_time_ff;
   reg  [2:0]  state_ff;
   reg  [4:0]  presc_cnt_ff;
   reg         clk_en_ff;
   reg  [4:0]  phase_cnt_ff;
   reg  [3:0]  conv_idx_ff;
   reg         wrapped_ff;
   reg         armed_ff;
   reg         done_ff;
   reg         trig_d_ff;
   reg  [2:0]  irq_stat_ff;
   reg  [2:0]  irq_en_ff;
   reg         aw_got_ff;
   reg         w_got_ff;
   reg  [7:0]  aw_addr_ff;
   reg  [31:0] w_data_ff;
   reg  [3:0]  w_strb_ff;

   // ***************************************************
   // helpers
   // ***************************************************
   function [3:0] seq_len;
      input [3:0] code;
      begin
         if (code == 4'h0 || code > `ADCSTC_LEN_MAX) begin
            seq_len = `ADCSTC_LEN_MAX; // [RULE16]
         end else begin
            seq_len = code; // [RULE16]
         end
      end
   endfunction

   function [4:0] samp_cycles;
      input [2:0] sel;
      begin
         case (sel) // [RULE3]
            3'h0: samp_cycles = 5'h04;
            3'h1: samp_cycles = 5'h06;
            3'h2: samp_cycles = 5'h08;
            3'h3: samp_cycles = 5'h0a;
            3'h4: samp_cycles = 5'h0c;
            3'h5: samp_cycles = 5'h10;
            3'h6: samp_cycles = 5'h14;
            default: samp_cycles = 5'h18;
         endcase
      end
   endfunction

   // external codes above five all map to input five
   function [3:0] ext_map;
      input [3:0] code;
      begin
         ext_map = (code > `ADCSTC_CH_LAST) ? `ADCSTC_CH_LAST : code; // [RULE14]
      end
   endfunction

   // next channel in multi mode: rollover after the wrap channel, or after five
   function [3:0] next_ch;
      input [3:0] cur;
      input [3:0] wrap;
      input       was_wrapped;
      begin
         if ((cur == wrap && (was_wrapped || cur <= wrap)) ||
             ext_map(cur) == `ADCSTC_CH_LAST) begin
            next_ch = 4'h0; // [RULE12] [RULE13]
         end else begin
            next_ch = cur + 4'h1; // [RULE11]
         end
      end
   endfunction

   // ***************************************************
   // bus write path
   // ***************************************************
   wire       wr_fire  = aw_got_ff && w_got_ff && !BVALID_OUT;
   wire       wr_lane0 = wr_fire && w_strb_ff[0];
   wire       wr_tim   = wr_lane0 && aw_addr_ff == `ADCSTC_ADDR_TIMING;
   wire       wr_start = wr_lane0 && aw_addr_ff == `ADCSTC_ADDR_START;
   wire       wr_ctl0  = wr_lane0 && aw_addr_ff == `ADCSTC_ADDR_CTL0;
   wire       wr_known = aw_addr_ff == `ADCSTC_ADDR_TIMING || aw_addr_ff == `ADCSTC_ADDR_START ||
                         aw_addr_ff == `ADCSTC_ADDR_CTL0 || aw_addr_ff == `ADCSTC_ADDR_STATUS ||
                         aw_addr_ff == `ADCSTC_ADDR_IRQ_STAT ||
                         aw_addr_ff == `ADCSTC_ADDR_IRQ_EN ||
                         aw_addr_ff == `ADCSTC_ADDR_IRQ_CLR ||
                         aw_addr_ff == `ADCSTC_ADDR_CONV_TIME;
   wire [7:0] new_start = w_data_ff[7:0];
   wire       trig_en  = ctl0_ff[`ADCSTC_ETRIG_BIT];
   wire       trig_edge = EXT_TRIGGER_IN && !trig_d_ff;
   wire       running  = state_ff != ST_IDLE;

   always @(posedge SYS_CLK_IN) begin
      if (SRST_IN) begin
         AWREADY_OUT <= 1'b0;
         WREADY_OUT  <= 1'b0;
         BVALID_OUT  <= 1'b0;
         BRESP_OUT   <= `ADCSTC_RESP_OKAY;
         aw_got_ff   <= 1'b0;
         w_got_ff    <= 1'b0;
         aw_addr_ff  <= 8'h00;
         w_data_ff   <= 32'h0000_0000;
         w_strb_ff   <= 4'h0;
      end else begin
         AWREADY_OUT <= !aw_got_ff && !AWREADY_OUT && AWVALID_IN;
         WREADY_OUT  <= !w_got_ff && !WREADY_OUT && WVALID_IN;
         if (AWVALID_IN && AWREADY_OUT) begin
            aw_got_ff  <= 1'b1;
            aw_addr_ff <= {AWADDR_IN[7:2], 2'b00};
         end
         if (WVALID_IN && WREADY_OUT) begin
            w_got_ff  <= 1'b1;
            w_data_ff <= WDATA_IN;
            w_strb_ff <= WSTRB_IN;
         end
         if (wr_fire) begin
            BVALID_OUT <= 1'b1;
            BRESP_OUT  <= wr_known ? `ADCSTC_RESP_OKAY : `ADCSTC_RESP_SLV;
            aw_got_ff  <= 1'b0;
            w_got_ff   <= 1'b0;
         end else if (BVALID_OUT && BREADY_IN) begin
            BVALID_OUT <= 1'b0;
         end
      end
   end

   // ***************************************************
   // bus read path, one cycle after address accept
   // ***************************************************
   wire [7:0] rd_addr = {ARADDR_IN[7:2], 2'b00};

   always @(posedge SYS_CLK_IN) begin
      if (SRST_IN) begin
         ARREADY_OUT <= 1'b0;
         RVALID_OUT  <= 1'b0;
         RDATA_OUT   <= 32'h0000_0000;
         RRESP_OUT   <= `ADCSTC_RESP_OKAY;
      end else begin
         ARREADY_OUT <= !ARREADY_OUT && !RVALID_OUT && ARVALID_IN;
         if (ARVALID_IN && ARREADY_OUT) begin
            RVALID_OUT <= 1'b1;
            RRESP_OUT  <= `ADCSTC_RESP_OKAY;
            if (rd_addr == `ADCSTC_ADDR_TIMING) begin
               RDATA_OUT <= {24'h0, timing_ff};
            end else if (rd_addr == `ADCSTC_ADDR_START) begin
               RDATA_OUT <= {24'h0, start_ff};
            end else if (rd_addr == `ADCSTC_ADDR_CTL0) begin
               RDATA_OUT <= {24'h0, ctl0_ff};
            end else if (rd_addr == `ADCSTC_ADDR_STATUS) begin
               RDATA_OUT <= {24'h0, armed_ff, running, done_ff, wrapped_ff, RESULT_SLOT_OUT};
            end else if (rd_addr == `ADCSTC_ADDR_IRQ_STAT) begin
               RDATA_OUT <= {29'h0, irq_stat_ff};
            end else if (rd_addr == `ADCSTC_ADDR_IRQ_EN) begin
               RDATA_OUT <= {29'h0, irq_en_ff};
            end else if (rd_addr == `ADCSTC_ADDR_IRQ_CLR) begin
               RDATA_OUT <= 32'h0000_0000;
            end else if (rd_addr == `ADCSTC_ADDR_CONV_TIME) begin
               RDATA_OUT <= {27'h0, conv_time_ff};
            end else begin
               RDATA_OUT <= 32'h0000_0000;
               RRESP_OUT <= `ADCSTC_RESP_SLV;
            end
         end else if (RVALID_OUT && RREADY_IN) begin
            RVALID_OUT <= 1'b0;
         end
      end
   end

   // ***************************************************
   // control registers
   // ***************************************************
   always @(posedge SYS_CLK_IN) begin
      if (SRST_IN) begin
         timing_ff    <= `ADCSTC_TIM_RST;
         start_ff     <= `ADCSTC_START_RST;
         ctl0_ff      <= `ADCSTC_CTL0_RST;
         conv_time_ff <= `ADCSTC_CONV_RST;
         irq_en_ff    <= 3'h0;
      end else begin
         if (wr_tim) timing_ff <= w_data_ff[7:0];
         if (wr_start) start_ff <= new_start;
         if (wr_ctl0) ctl0_ff <= w_data_ff[7:0];
         if (wr_lane0 && aw_addr_ff == `ADCSTC_ADDR_CONV_TIME) begin
            conv_time_ff <= (w_data_ff[4:0] == 5'h00) ? 5'h01 : w_data_ff[4:0];
         end
         if (wr_lane0 && aw_addr_ff == `ADCSTC_ADDR_IRQ_EN) irq_en_ff <= w_data_ff[2:0];
      end
   end

   // ***************************************************
   // prescaler: half period of prs+1 bus cycles
   // ***************************************************
   always @(posedge SYS_CLK_IN) begin
      if (SRST_IN || wr_tim) begin
         presc_cnt_ff    <= 5'h00; // [RULE19]
         clk_en_ff       <= 1'b0;
         CONV_CLK_EN_OUT <= 1'b0;
      end else if (presc_cnt_ff == timing_ff[4:0]) begin
         presc_cnt_ff    <= 5'h00;
         clk_en_ff       <= !clk_en_ff;
         CONV_CLK_EN_OUT <= !clk_en_ff; // [RULE4] [RULE19]
      end else begin
         presc_cnt_ff    <= presc_cnt_ff + 5'h01;
         CONV_CLK_EN_OUT <= 1'b0;
      end
   end

   // ***************************************************
   // sequencer
   // ***************************************************
   wire tick      = CONV_CLK_EN_OUT;
   wire trig_go   = trig_en && armed_ff && trig_edge && !wr_start;
   wire last_conv = conv_idx_ff + 4'h1 >= seq_len(ctl0_ff[3:0]);
   // every repeated sequence restarts at the start code, mapped for external channels only
   wire [3:0] start_ch = start_ff[`ADCSTC_SC_BIT] ? start_ff[3:0]
                         : ext_map(start_ff[3:0]); // [RULE11] [RULE14]

   always @(posedge SYS_CLK_IN) begin
      if (SRST_IN) begin
         state_ff        <= ST_IDLE;
         phase_cnt_ff    <= 5'h00;
         conv_idx_ff     <= 4'h0;
         wrapped_ff      <= 1'b0;
         armed_ff        <= 1'b0;
         done_ff         <= 1'b0;
         trig_d_ff       <= 1'b0;
         irq_stat_ff     <= 3'h0;
         SAMPLE_OUT      <= 1'b0;
         CONVERT_OUT     <= 1'b0;
         CONV_START_OUT  <= 1'b0;
         SPECIAL_SEL_OUT <= 1'b0;
         CHANNEL_OUT     <= 4'h0;
         RESULT_SLOT_OUT <= 4'h0;
         BUSY_OUT        <= 1'b0;
         IRQ_OUT         <= 1'b0;
      end else begin
         trig_d_ff      <= EXT_TRIGGER_IN;
         CONV_START_OUT <= 1'b0;
         if (wr_lane0 && aw_addr_ff == `ADCSTC_ADDR_IRQ_CLR) begin
            irq_stat_ff <= irq_stat_ff & ~w_data_ff[2:0];
         end
         if (wr_lane0 && aw_addr_ff == `ADCSTC_ADDR_STATUS && w_data_ff[5]) done_ff <= 1'b0;
         if (wr_tim || wr_ctl0) begin
            state_ff        <= ST_IDLE; // [RULE1]
            RESULT_SLOT_OUT <= 4'h0; // [RULE17]
            conv_idx_ff     <= 4'h0;
            armed_ff        <= 1'b0;
            SAMPLE_OUT      <= 1'b0;
            CONVERT_OUT     <= 1'b0;
            BUSY_OUT        <= 1'b0;
            if (running) irq_stat_ff[`ADCSTC_IRQ_ABORT] <= 1'b1;
         end else if (wr_start || trig_go) begin
            // new sequence; sampling starts on the next cycle, together with the start pulse
            state_ff        <= ST_SAMP; // [RULE2] [RULE5] [RULE6]
            phase_cnt_ff    <= samp_cycles(timing_ff[7:5]);
            conv_idx_ff     <= 4'h0;
            wrapped_ff      <= 1'b0;
            RESULT_SLOT_OUT <= 4'h0; // [RULE17]
            SAMPLE_OUT      <= 1'b1;
            CONVERT_OUT     <= 1'b0;
            CONV_START_OUT  <= 1'b1;
            BUSY_OUT        <= 1'b1;
            if (wr_start) begin
               done_ff         <= 1'b0; // [RULE18]
               armed_ff        <= 1'b1; // [RULE5]
               SPECIAL_SEL_OUT <= new_start[`ADCSTC_SC_BIT]; // [RULE7]
               CHANNEL_OUT     <= new_start[`ADCSTC_SC_BIT] ? new_start[3:0]
                                  : ext_map(new_start[3:0]); // [RULE14] [RULE15]
            end else begin
               CHANNEL_OUT <= start_ff[`ADCSTC_SC_BIT] ? start_ff[3:0] : ext_map(start_ff[3:0]);
            end
            if (running && trig_go) irq_stat_ff[`ADCSTC_IRQ_OVR] <= 1'b1;
         end else begin
            if (trig_edge && running && trig_en) irq_stat_ff[`ADCSTC_IRQ_OVR] <= 1'b1;
            case (state_ff)
               ST_SAMP: begin
                  if (tick) begin
                     if (phase_cnt_ff == 5'h01) begin
                        state_ff     <= ST_CONV;
                        SAMPLE_OUT   <= 1'b0;
                        CONVERT_OUT  <= 1'b1;
                        phase_cnt_ff <= conv_time_ff;
                     end else begin
                        phase_cnt_ff <= phase_cnt_ff - 5'h01; // [RULE3]
                     end
                  end
               end
               ST_CONV: begin
                  if (CONV_DONE_IN || (tick && phase_cnt_ff == 5'h01)) begin
                     CONVERT_OUT     <= 1'b0;
                     RESULT_SLOT_OUT <= RESULT_SLOT_OUT + 4'h1;
                     if (start_ff[`ADCSTC_MULTI_CHANNEL_MODE_BIT]) begin
                        CHANNEL_OUT <= next_ch(CHANNEL_OUT, ctl0_ff[7:4] & 4'h7,
                                               wrapped_ff); // [RULE11] [RULE12] [RULE13]
                        if (next_ch(CHANNEL_OUT, ctl0_ff[7:4] & 4'h7, wrapped_ff) == 4'h0) begin
                           wrapped_ff <= 1'b1;
                        end
                     end
                     if (last_conv) begin
                        done_ff <= 1'b1;
                        irq_stat_ff[`ADCSTC_IRQ_DONE] <= 1'b1;
                        conv_idx_ff     <= 4'h0;
                        RESULT_SLOT_OUT <= 4'h0;
                        if (start_ff[`ADCSTC_SCAN_BIT] && !trig_en) begin
                           state_ff       <= ST_SAMP; // [RULE8] [RULE9]
                           SAMPLE_OUT     <= 1'b1;
                           CONV_START_OUT <= 1'b1;
                           phase_cnt_ff   <= samp_cycles(timing_ff[7:5]);
                           wrapped_ff     <= 1'b0;
                           CHANNEL_OUT    <= start_ch;
                        end else begin
                           state_ff <= ST_IDLE; // [RULE9]
                           BUSY_OUT <= 1'b0;
                        end
                     end else begin
                        // single-channel mode keeps the same channel [RULE10]
                        conv_idx_ff    <= conv_idx_ff + 4'h1;
                        state_ff       <= ST_SAMP;
                        SAMPLE_OUT     <= 1'b1;
                        CONV_START_OUT <= 1'b1;
                        phase_cnt_ff   <= samp_cycles(timing_ff[7:5]);
                     end
                  end else if (tick) begin
                     phase_cnt_ff <= phase_cnt_ff - 5'h01;
                  end
               end
               default: begin
                  state_ff <= ST_IDLE;
               end
            endcase
         end
         IRQ_OUT <= |(irq_stat_ff & irq_en_ff);
      end
   end
endmodule // adcstc_top
`default_nettype wire

// ===== design/adcstc_defs.vh
// Function
// (RULE1) writing the timing register aborts any running sequence
// (RULE2) writing the start register aborts and starts a new sequence with new settings
// (RULE3) sample select bits 7-5 give 4,6,8,10,12,16,20,24 conversion clocks
// (RULE4) prescale bits 4-0: conversion clock is bus clock over 2*(value+1)
// (RULE5) with trigger enabled, one start write arms; each trigger then starts a sequence
// (RULE6) conversion start is the first cycle of the sampling phase
// (RULE7) special channel bit 6 selects internal channels instead of external inputs
// (RULE8) continuous bit 5 repeats sequences back to back
// (RULE9) with trigger enabled, continuous bit ignored; one sequence per trigger
// (RULE10) multi bit 4 clear: every conversion uses the one coded channel
// (RULE11) multi bit set: sequence-length channels, incrementing from the code
// (RULE12) after the rollover channel the next channel is input zero
// (RULE13) starting above rollover channel, first return to zero follows input five
// (RULE14) external codes 0-5 pick inputs 0-5; codes 6-15 pick input five
// (RULE15) special codes map temperature, internals, references, midpoint; 7,12-15 reserved
// (RULE16) length codes 1-6 give count, others six; reset length four
// (RULE17) abort or start clears the result slot counter, even circular mode
// (RULE18) start register write clears the sequence done flag
// (RULE19) prescaler counts bus cycles, restarts when the prescale field is written
`ifndef ADCSTC_DEFS_VH
`define ADCSTC_DEFS_VH
// ***************************************************
// register byte addresses
// ***************************************************
// each register is one aligned word: byte address is four times its index
`define ADCSTC_ADDR_CTL0      8'h00
`define ADCSTC_ADDR_TIMING    8'h10
`define ADCSTC_ADDR_START     8'h14
`define ADCSTC_ADDR_STATUS    8'h08
`define ADCSTC_ADDR_IRQ_STAT  8'h0c
`define ADCSTC_ADDR_IRQ_EN    8'h18
`define ADCSTC_ADDR_IRQ_CLR   8'h1c
`define ADCSTC_ADDR_CONV_TIME 8'h20
// ***************************************************
// fields and reset values
// ***************************************************
`define ADCSTC_TIM_RST    8'h05
`define ADCSTC_START_RST  8'h00
`define ADCSTC_CTL0_RST   8'h44
`define ADCSTC_LEN_RST    4'h4
`define ADCSTC_LEN_MAX    4'h6
`define ADCSTC_CH_LAST    4'h5
`define ADCSTC_CONV_RST   5'h0a
`define ADCSTC_SC_BIT     6
`define ADCSTC_SCAN_BIT   5
`define ADCSTC_MULTI_CHANNEL_MODE_BIT   4
`define ADCSTC_ETRIG_BIT  7
`define ADCSTC_IRQ_DONE   0
`define ADCSTC_IRQ_ABORT  1
`define ADCSTC_IRQ_OVR    2
`define ADCSTC_RESP_OKAY  2'b00
`define ADCSTC_RESP_SLV   2'b10
`endif

// ===== bench/adcstc_assertions.sv
`default_nettype none
module adcstc_checker (
   input wire logic       SYS_CLK_IN,
   input wire logic       SRST_IN,
   input wire logic       CONV_CLK_EN_OUT,
   input wire logic       SAMPLE_OUT,
   input wire logic       CONVERT_OUT,
   input wire logic       CONV_START_OUT,
   input wire logic       SPECIAL_SEL_OUT,
   input wire logic [3:0] CHANNEL_OUT,
   input wire logic [3:0] RESULT_SLOT_OUT,
   input wire logic       BUSY_OUT
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge SYS_CLK_IN); endclocking
   default disable iff (SRST_IN);
   // ***************************************************
   // sequencing properties
   // ***************************************************
   property p_start_in_sample; CONV_START_OUT |-> SAMPLE_OUT; endproperty
   a_start_in_sample: assert property (p_start_in_sample) else $error("start outside sampling");
   property p_sample_rise; $rose(SAMPLE_OUT) |-> CONV_START_OUT; endproperty
   a_sample_rise: assert property (p_sample_rise) else $error("sampling began without start");
   property p_start_pulse; CONV_START_OUT |=> !CONV_START_OUT; endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
   property p_phase_excl; !(SAMPLE_OUT && CONVERT_OUT); endproperty
   a_phase_excl: assert property (p_phase_excl) else $error("sample and convert overlap");
   // the enable period is 2*(prescale+1), never shorter than two bus cycles
   property p_clk_en; CONV_CLK_EN_OUT |=> !CONV_CLK_EN_OUT; endproperty
   a_clk_en: assert property (p_clk_en) else $error("conversion clock enable too fast");
   property p_clamp; (SAMPLE_OUT && !SPECIAL_SEL_OUT) |-> CHANNEL_OUT <= 4'h5; endproperty
   a_clamp: assert property (p_clamp) else $error("external channel above five");
   property p_slot_clear; $rose(BUSY_OUT) |-> RESULT_SLOT_OUT == 4'h0; endproperty
   a_slot_clear: assert property (p_slot_clear) else $error("slot counter not cleared");
   property p_phase_busy; (SAMPLE_OUT || CONVERT_OUT) |-> BUSY_OUT; endproperty
   a_phase_busy: assert property (p_phase_busy) else $error("phase while idle");
   property p_mux_stable;
      (SAMPLE_OUT && $past(SAMPLE_OUT) && !CONV_START_OUT) |->
         $stable(CHANNEL_OUT) && $stable(SPECIAL_SEL_OUT);
   endproperty
   a_mux_stable: assert property (p_mux_stable) else $error("channel moved while sampling");
endmodule // adcstc_checker
bind adcstc_top adcstc_checker i_chk (.SYS_CLK_IN, .SRST_IN, .CONV_CLK_EN_OUT, .SAMPLE_OUT,
   .CONVERT_OUT, .CONV_START_OUT, .SPECIAL_SEL_OUT, .CHANNEL_OUT, .RESULT_SLOT_OUT, .BUSY_OUT);
`default_nettype wire

// ===== bench/adcstc_macro_model.sv
`default_nettype none
module adcstc_macro_model (
   input  wire logic       clk_in,
   input  wire logic       start_in,
   input  wire logic       convert_in,
   input  wire logic       special_in,
   input  wire logic [3:0] channel_in,
   input  wire logic       quick_in,
   output var  logic       done_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] seen[$];
   int         conv_cnt = 0;
   // quick mode ends each conversion early, otherwise the block times it alone
   always @(posedge clk_in) begin
      if (start_in === 1'b1) seen.push_back({special_in, channel_in});
      conv_cnt <= (convert_in === 1'b1) ? conv_cnt + 1 : 0;
      done_out <= quick_in && (convert_in === 1'b1) && (conv_cnt == 3);
   end
endmodule // adcstc_macro_model
`default_nettype wire

// ===== bench/tb.sv
`include "adcstc_defs.vh"
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   // register indices; byte address is four times the index
   localparam int TIM_IDX = 4;
   localparam int ST_IDX  = 5;
   localparam logic [7:0] A_TIM = 8'(TIM_IDX * 4);
   localparam logic [7:0] A_ST  = 8'(ST_IDX * 4);
   logic clk = 0, rst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, trig = 0, quick = 0;
   logic [7:0]  awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0, rdv;
   logic [1:0]  resp;
   wire logic awr, wrd, bv, arr, rv, done, cen, samp, conv, cst, spec, busy, irq;
   wire logic [1:0] br, rr;
   wire logic [31:0] rdat;
   wire logic [3:0] ch, slot;
   int n_fail = 0, checks_done = 0, smp_cnt = 0, gap = 0, last_gap = 0, n0;
   int smp_tab[8] = '{4, 6, 8, 10, 12, 16, 20, 24};
   always #20 clk = ~clk;
   always @(posedge clk) begin
      if (samp === 1'b1 && cen === 1'b1) smp_cnt++;
      gap++;
      if (cen === 1'b1) begin
         last_gap = gap;
         gap = 0;
      end
   end
   adcstc_top i_adcstc_top (.SYS_CLK_IN(clk), .SRST_IN(rst), .AWADDR_IN(awa), .AWVALID_IN(awv),
      .AWREADY_OUT(awr), .WDATA_IN(wd), .WSTRB_IN(4'h1), .WVALID_IN(wv), .WREADY_OUT(wrd),
      .BRESP_OUT(br), .BVALID_OUT(bv), .BREADY_IN(bre), .ARADDR_IN(ara), .ARVALID_IN(arv),
      .ARREADY_OUT(arr), .RDATA_OUT(rdat), .RRESP_OUT(rr), .RVALID_OUT(rv), .RREADY_IN(rre),
      .EXT_TRIGGER_IN(trig), .CONV_DONE_IN(done), .CONV_CLK_EN_OUT(cen), .SAMPLE_OUT(samp),
      .CONVERT_OUT(conv), .CONV_START_OUT(cst), .SPECIAL_SEL_OUT(spec), .CHANNEL_OUT(ch),
      .RESULT_SLOT_OUT(slot), .BUSY_OUT(busy), .IRQ_OUT(irq));
   adcstc_macro_model i_mdl (.clk_in(clk), .start_in(cst), .convert_in(conv),
      .special_in(spec), .channel_in(ch), .quick_in(quick), .done_out(done));
   // ***************************************************
   // bus tasks
   // ***************************************************
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bre <= 1'b1;
      do begin
         @(posedge clk);
         if (awr === 1'b1) awv <= 1'b0;
         if (wrd === 1'b1) wv <= 1'b0;
      end while (bv !== 1'b1);
      bre <= 1'b0;
      resp = br;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rre <= 1'b1;
      do begin
         @(posedge clk);
         if (arr === 1'b1) arv <= 1'b0;
      end while (rv !== 1'b1);
      rre <= 1'b0;
      rdv = rdat;
      resp = rr;
   endtask
   task automatic idle;
      repeat (3) @(posedge clk);
      while (busy !== 1'b0) @(posedge clk);
   endtask
   // runs one sequence and compares every channel the macro was given
   task automatic seq(input logic [7:0] c0, input logic [7:0] st, input int n,
                      input logic [29:0] ex);
      wr(`ADCSTC_ADDR_CTL0, {24'h0, c0});
      i_mdl.seen.delete();
      wr(A_ST, {24'h0, st});
      idle();
      chk(i_mdl.seen.size(), n);
      for (int i = 0; i < n && i < i_mdl.seen.size(); i++) chk(i_mdl.seen[i], ex[29-5*i -: 5]);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // ***************************************************
   // tests
   // ***************************************************
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd(`ADCSTC_ADDR_CTL0); chk(rdv, 32'h44);
      rd(A_TIM); chk(rdv, 32'h05);
      rd(A_ST); chk(rdv, 32'h00);
      rd(8'h40); chk(resp, 2'b10);
      wr(`ADCSTC_ADDR_CTL0, 32'h31);
      for (int s = 0; s < 8; s++) begin
         wr(A_TIM, {24'h0, 3'(s), 5'(s * 4 + 3)});
         smp_cnt = 0;
         wr(A_ST, 32'h02);
         idle();
         chk(smp_cnt, smp_tab[s]);
         chk(last_gap, 2 * (s * 4 + 4));
      end
      wr(A_TIM, 32'h00);
      seq(8'h36, 8'h11, 6, {5'h01, 5'h02, 5'h03, 5'h00, 5'h01, 5'h02});
      seq(8'h36, 8'h14, 6, {5'h04, 5'h05, 5'h00, 5'h01, 5'h02, 5'h03});
      seq(8'h33, 8'h09, 3, {5'h05, 5'h05, 5'h05, 15'h0});
      seq(8'h31, 8'h46, 1, {5'h16, 25'h0});
      seq(8'h30, 8'h40, 6, {6{5'h10}});
      seq(8'h37, 8'h48, 6, {6{5'h18}});
      wr(`ADCSTC_ADDR_CTL0, 32'h31);
      i_mdl.seen.delete();
      wr(A_ST, 32'h2a);
      repeat (200) @(posedge clk);
      chk(i_mdl.seen.size() > 3, 1);
      chk(i_mdl.seen[$], 5'h05);
      chk(last_gap, 2);
      wr(A_TIM, 32'h00);
      repeat (3) @(posedge clk);
      chk(busy, 1'b0);
      wr(`ADCSTC_ADDR_CTL0, 32'h36);
      wr(A_ST, 32'h30);
      while (slot === 4'h0) @(posedge clk);
      wr(A_ST, 32'h15);
      #1 chk(slot, 4'h0);
      idle();
      chk(i_mdl.seen[$-5], 5'h05);
      chk(i_mdl.seen[$], 5'h00);
      quick <= 1'b1;
      wr(`ADCSTC_ADDR_CTL0, 32'h82);
      wr(A_ST, 32'h20);
      idle();
      n0 = i_mdl.seen.size();
      for (int k = 1; k < 3; k++) begin
         @(posedge clk);
         trig <= 1'b1;
         repeat (2) @(posedge clk);
         trig <= 1'b0;
         idle();
         chk(i_mdl.seen.size() - n0, 2 * k);
      end
      quick <= 1'b0;
      wr(`ADCSTC_ADDR_CTL0, 32'h31);
      wr(`ADCSTC_ADDR_IRQ_CLR, 32'h07);
      wr(`ADCSTC_ADDR_IRQ_EN, 32'h01);
      wr(A_ST, 32'h01);
      idle();
      repeat (2) @(posedge clk);
      chk(irq, 1'b1);
      rd(`ADCSTC_ADDR_STATUS); chk(rdv[5], 1'b1);
      wr(`ADCSTC_ADDR_IRQ_CLR, 32'h01);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
      wr(`ADCSTC_ADDR_IRQ_EN, 32'h00);
      wr(A_ST, 32'h01);
      rd(`ADCSTC_ADDR_STATUS); chk(rdv[5], 1'b0);
      idle();
      chk(irq, 1'b0);
      rd(`ADCSTC_ADDR_IRQ_STAT); chk(rdv[0], 1'b1);
      results();
   end
   initial begin
      #(40ns * 60000);
      n_fail++;
      results();
   end
endmodule // tb
`default_nettype wire
